// *** core/wsp_idle_timer.sv ***
// Idle threshold timer that moves one block into its low power state
`timescale 1ns/1ns
`default_nettype none
module wsp_idle_timer
   import wsp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       tick_i,
   input  wire logic       busy_i,
   input  wire logic       hold_i,
   input  wire logic [7:0] thresh_i,
   output logic            lp_o
);
   logic [7:0] cnt_r;
   wire        stay_up = busy_i | hold_i;
   wire        reached = (cnt_r >= thresh_i);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_r <= 8'h00;
         lp_o  <= 1'b0;
      end
      else if (stay_up)
      begin
         cnt_r <= 8'h00;
         lp_o  <= 1'b0;
      end
      else if (reached)
         lp_o  <= 1'b1;
      else if (tick_i)
         cnt_r <= cnt_r + 8'h01;
   end

   idle_lp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      stay_up |=> !lp_o) else $error("block in low power while busy");
endmodule
`default_nettype wire

// *** core/wsp_pkg.sv ***
// Constants, types and mode encodings for the wireless subsystem power sequencer
// ==========================================================================
package wsp_pkg;
   localparam int TU_PS        = 1024000;
   localparam int CLK_PS       = 40000;
   localparam int TU_CYC       = TU_PS / CLK_PS;
   localparam int MAX_SLEEP_MS = 2000;
   localparam logic [11:0] MAX_SLEEP_TU = 12'(MAX_SLEEP_MS * 1000000 / TU_PS);
   localparam logic [11:0] BEACON_TU    = 12'h064;
   localparam logic [7:0]  NORMAL_IDLE_TU = 8'h04;
   localparam logic [7:0]  ZERO_IDLE_TU   = 8'h00;
   localparam int BOOT_CYC_DEF = 64;
   localparam int STAB_CYC_DEF = 32;
   localparam int NBLK         = 2;
   localparam int BLK_RADIO    = 0;
   localparam int BLK_NP       = 1;

   typedef enum logic [2:0] {
      MCU_SHUTDOWN, MCU_HIBERNATE, MCU_DEEP, MCU_SLEEP, MCU_ACTIVE
   } wsp_mcu_t;
   typedef enum logic [2:0] {
      CHIP_SHUTDOWN, CHIP_HIBERNATE, CHIP_DEEP, CHIP_ACTIVE
   } wsp_chip_t;
   typedef enum logic [1:0] {
      POL_NORMAL, POL_LOW, POL_LONG, POL_ALWAYS
   } wsp_pol_t;
   typedef enum logic [1:0] {
      SS_OFF, SS_BOOT, SS_RUN, SS_STOP
   } wsp_ss_t;

   typedef struct packed {
      logic rail_low;
      logic xtal_pll_off;
      logic mem_retain;
      logic rtc_run;
      logic mem_lost;
      logic mcu_clk_gated;
   } wsp_pwr_t;

   localparam wsp_pwr_t PWR_RST = '{default: 1'b0};
endpackage

// *** core/wsp_power_seq.sv ***
// Power mode sequencer for the microcontroller and networking subsystem
`timescale 1ns/1ns
`default_nettype none
module wsp_power_seq
   import wsp_pkg::*;
#(
   parameter int TU_CYCLES = TU_CYC,
   parameter int BOOT_CYC  = BOOT_CYC_DEF,
   parameter int STAB_CYC  = STAB_CYC_DEF
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire wsp_mcu_t    mcu_mode_req_i,
   input  wire logic        wfi_i,
   input  wire logic        wfe_i,
   input  wire logic        mcu_wake_i,
   input  wire logic        integrated_i,
   input  wire logic        hibernate_control_pin_i,
   input  wire logic        internal_enable_i,
   input  wire logic        stop_cmd_i,
   input  wire logic [15:0] stop_timeout_tu_i,
   input  wire logic        host_cmd_i,
   input  wire logic        evt_i,
   input  wire logic        evt_status_read_i,
   input  wire logic        start_status_read_i,
   input  wire logic        radio_busy_i,
   input  wire logic        np_busy_i,
   input  wire logic        predicted_activity_i,
   input  wire logic        associated_i,
   input  wire logic        client_mode_i,
   input  wire wsp_pol_t    policy_sel_i,
   input  wire logic        policy_we_i,
   input  wire logic [11:0] max_sleep_tu_i,
   input  wire logic [2:0]  dtim_period_i,
   output wsp_chip_t        chip_mode_o,
   output wsp_mcu_t         mcu_mode_o,
   output wsp_pwr_t         pwr_o,
   output logic             host_irq_o,
   output logic             init_done_o,
   output logic             radio_wake_o,
   output logic             power_save_en_o,
   output logic             mdns_stop_o,
   output logic             web_stop_o,
   output logic             slow_clk_stab_o
);
   // ==========================================================================
   // Pin synchroniser for the hibernate control pin
   logic [2:0] hib_s_r;
   logic       hib_r;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hib_s_r <= 3'h0;
         hib_r   <= 1'b0;
      end
      else
      begin
         hib_s_r <= {hib_s_r[1:0], hibernate_control_pin_i};
         if (hib_s_r[1] == hib_s_r[2])
            hib_r <= hib_s_r[2];
      end
   end
   wire enable_req = integrated_i ? internal_enable_i : hib_r;

   // ==========================================================================
   // Time unit and beacon timing
   logic [15:0] tu_cnt_r;
   logic [11:0] bcn_cnt_r;
   logic [2:0]  dtim_cnt_r;
   logic [11:0] elapsed_r;
   wire tu_tick  = (tu_cnt_r == 16'(TU_CYCLES - 1));
   wire bcn_tick = tu_tick && (bcn_cnt_r == BEACON_TU - 12'h001);
   wire [2:0]  dtim_eff = (dtim_period_i == 3'h0) ? 3'h1 : dtim_period_i;
   wire dtim_bcn = bcn_tick && (dtim_cnt_r == dtim_eff - 3'h1);
   wire [11:0] max_eff = (max_sleep_tu_i > MAX_SLEEP_TU) ? MAX_SLEEP_TU
                                                        : max_sleep_tu_i;
   wire [14:0] dtim_gap = 15'(BEACON_TU) * 15'(dtim_eff);
   wire [14:0] next_at  = 15'(elapsed_r) + 15'h0001 + dtim_gap;

   // ==========================================================================
   // Microcontroller mode
   wsp_mcu_t   mcu_r;
   logic [7:0] stab_r;
   wire stab_busy = (stab_r != 8'h00);
   wire wait_ins  = wfi_i | wfe_i;
   wsp_mcu_t   mcu_nxt;
   always_comb
   begin
      mcu_nxt = mcu_r;
      case (mcu_r)
         MCU_SHUTDOWN:
            if (mcu_mode_req_i != MCU_SHUTDOWN && !stab_busy && slow_clk_stab_o)
               mcu_nxt = MCU_ACTIVE;
         MCU_SLEEP:
            if (mcu_wake_i)
               mcu_nxt = MCU_ACTIVE;
         MCU_ACTIVE:
            if (wait_ins)
               mcu_nxt = MCU_SLEEP;
            else if (mcu_mode_req_i != MCU_SLEEP)
               mcu_nxt = mcu_mode_req_i;
         MCU_HIBERNATE, MCU_DEEP:
            if (mcu_mode_req_i != MCU_SLEEP)
               mcu_nxt = mcu_mode_req_i;
         default:
            mcu_nxt = MCU_ACTIVE;
      endcase
   end
   wire leave_shut = (mcu_r == MCU_SHUTDOWN) && (mcu_mode_req_i != MCU_SHUTDOWN);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mcu_r           <= MCU_ACTIVE;
         stab_r          <= 8'h00;
         slow_clk_stab_o <= 1'b0;
      end
      else
      begin
         mcu_r <= mcu_nxt;
         if (leave_shut && !slow_clk_stab_o && !stab_busy)
         begin
            stab_r          <= 8'(STAB_CYC);
            slow_clk_stab_o <= 1'b1;
         end
         else if (stab_busy)
            stab_r <= stab_r - 8'h01;
         else if (mcu_r != MCU_SHUTDOWN)
            slow_clk_stab_o <= 1'b0;
      end
   end

   // ==========================================================================
   // Subsystem enable, boot and stop
   wsp_ss_t     ss_r;
   wsp_ss_t     ss_nxt;
   logic [7:0]  boot_r;
   logic [15:0] stop_r;
   logic        irq_r;
   logic        start_pend_r;
   wire shut    = (mcu_r == MCU_SHUTDOWN);
   wire boot_end = (ss_r == SS_BOOT) && (boot_r == 8'h00);
   always_comb
   begin
      ss_nxt = ss_r;
      case (ss_r)
         SS_OFF:  if (enable_req && !shut) ss_nxt = SS_BOOT;
         SS_BOOT: if (boot_end)             ss_nxt = SS_RUN;
         SS_RUN:  if (stop_cmd_i)           ss_nxt = SS_STOP;
                  else if (!enable_req)     ss_nxt = SS_OFF;
         SS_STOP: if (!enable_req || stop_r == 16'h0000) ss_nxt = SS_OFF;
         default: ss_nxt = SS_OFF;
      endcase
      if (shut)
         ss_nxt = SS_OFF;
   end

   wire irq_set = boot_end || ((ss_r == SS_RUN) && evt_i);
   wire irq_clr = evt_status_read_i || start_status_read_i || (ss_r == SS_OFF);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ss_r         <= SS_OFF;
         boot_r       <= 8'h00;
         stop_r       <= 16'h0000;
         irq_r        <= 1'b0;
         start_pend_r <= 1'b0;
         init_done_o  <= 1'b0;
      end
      else
      begin
         ss_r   <= ss_nxt;
         boot_r <= (ss_r == SS_OFF) ? 8'(BOOT_CYC) : (boot_end ? boot_r : boot_r - 8'h01);
         if (ss_r == SS_RUN && stop_cmd_i)
            stop_r <= stop_timeout_tu_i;
         else if (ss_r == SS_STOP && tu_tick && stop_r != 16'h0000)
            stop_r <= stop_r - 16'h0001;
         irq_r <= irq_set | (irq_r & ~irq_clr);
         start_pend_r <= boot_end | (start_pend_r & ~start_status_read_i & (ss_r != SS_OFF));
         if (ss_r == SS_OFF)
            init_done_o <= 1'b0;
         else if (start_pend_r && start_status_read_i)
            init_done_o <= 1'b1;
      end
   end
   wire run = (ss_r == SS_RUN) || (ss_r == SS_STOP);

   // ==========================================================================
   // Power policy
   wsp_pol_t pol_r;
   wsp_pol_t pend_r;
   logic     pend_v_r;
   wire extended_beacon_skip_policy  = (pol_r == POL_LONG) && client_mode_i;
   wire aon  = (pol_r == POL_ALWAYS);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pol_r    <= POL_NORMAL;
         pend_r   <= POL_NORMAL;
         pend_v_r <= 1'b0;
      end
      else
      begin
         if (policy_we_i)
            pend_r <= policy_sel_i;
         pend_v_r <= policy_we_i | (pend_v_r & ~tu_tick);
         if (ss_r == SS_BOOT)
            pol_r <= POL_NORMAL;
         else if (pend_v_r && tu_tick)
            pol_r <= pend_r;
      end
   end

   // ==========================================================================
   // Beacon wake scheduling
   wire wake_lsi  = dtim_bcn && (next_at > 15'(max_eff));
   wire wake_now  = run && associated_i && !aon && (extended_beacon_skip_policy ? wake_lsi : bcn_tick);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tu_cnt_r     <= 16'h0000;
         bcn_cnt_r    <= 12'h000;
         dtim_cnt_r   <= 3'h0;
         elapsed_r    <= 12'h000;
         radio_wake_o <= 1'b0;
      end
      else
      begin
         tu_cnt_r <= tu_tick ? 16'h0000 : tu_cnt_r + 16'h0001;
         if (tu_tick)
            bcn_cnt_r <= bcn_tick ? 12'h000 : bcn_cnt_r + 12'h001;
         if (bcn_tick)
            dtim_cnt_r <= dtim_bcn ? 3'h0 : dtim_cnt_r + 3'h1;
         if (wake_now || !run)
            elapsed_r <= 12'h000;
         else if (tu_tick && elapsed_r != 12'hfff)
            elapsed_r <= elapsed_r + 12'h001;
         radio_wake_o <= wake_now;
      end
   end

   // ==========================================================================
   // Per-block idle timers
   wire [7:0] thresh = (pol_r == POL_LOW) ? ZERO_IDLE_TU : NORMAL_IDLE_TU;
   wire hold_pred  = (pol_r == POL_NORMAL) && predicted_activity_i;
   wire [NBLK-1:0] busy;
   wire [NBLK-1:0] hold;
   wire [NBLK-1:0] lp;
   assign busy[BLK_RADIO] = radio_busy_i | wake_now;
   assign busy[BLK_NP]    = np_busy_i | host_cmd_i;
   assign hold[BLK_RADIO] = !run | aon | hold_pred;
   assign hold[BLK_NP]    = !run | aon | hold_pred | irq_r;
   genvar g;
   generate
      for (g = 0; g < NBLK; g++)
      begin : g_blk
         wsp_idle_timer u_tmr (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .tick_i   (tu_tick),
            .busy_i   (busy[g]),
            .hold_i   (hold[g]),
            .thresh_i (thresh),
            .lp_o     (lp[g])
         );
      end
   endgenerate
   wire ss_deep = run && (&lp) && !irq_r;

   // ==========================================================================
   // Chip mode and power controls
   wsp_chip_t chip_nxt;
   always_comb
   begin
      case (mcu_r)
         MCU_SHUTDOWN:  chip_nxt = CHIP_SHUTDOWN;
         MCU_HIBERNATE: chip_nxt = CHIP_HIBERNATE;
         MCU_DEEP:      chip_nxt = (run && !ss_deep) ? CHIP_ACTIVE : CHIP_DEEP;
         default:       chip_nxt = CHIP_ACTIVE;
      endcase
   end
   wire deep_nxt = (chip_nxt == CHIP_DEEP);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         chip_mode_o     <= CHIP_ACTIVE;
         mcu_mode_o      <= MCU_ACTIVE;
         pwr_o           <= PWR_RST;
         host_irq_o      <= 1'b0;
         power_save_en_o <= 1'b0;
         mdns_stop_o     <= 1'b0;
         web_stop_o      <= 1'b0;
      end
      else
      begin
         chip_mode_o            <= chip_nxt;
         mcu_mode_o             <= mcu_r;
         pwr_o.rail_low         <= deep_nxt;
         pwr_o.xtal_pll_off     <= deep_nxt;
         pwr_o.mem_retain       <= deep_nxt;
         pwr_o.rtc_run          <= (mcu_r != MCU_SHUTDOWN);
         pwr_o.mem_lost         <= (mcu_r == MCU_SHUTDOWN);
         pwr_o.mcu_clk_gated    <= (mcu_r == MCU_SLEEP);
         host_irq_o             <= irq_r;
         power_save_en_o        <= run && !aon;
         mdns_stop_o            <= extended_beacon_skip_policy;
         web_stop_o             <= extended_beacon_skip_policy;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   irq_hold_a: assert property (irq_r && !irq_clr |=> irq_r)
      else $error("interrupt dropped before status read");
   deep_irq_a: assert property (irq_r && $past(irq_r) |-> !(&lp))
      else $error("deep sleep with interrupt pending");
   boot_irq_a: assert property (boot_end |=> irq_r && ss_r == SS_RUN)
      else $error("boot end without interrupt");
   stop_tmo_a: assert property (ss_r == SS_STOP && stop_r == 16'h0000 |=> ss_r == SS_OFF)
      else $error("stop timeout not honoured");
   always_on_a: assert property (aon && run |=> ##1 !lp[BLK_RADIO] && !lp[BLK_NP])
      else $error("always-on block in low power");
   sleep_gate_a: assert property (mcu_r == MCU_SLEEP |=> pwr_o.mcu_clk_gated
      && chip_mode_o == CHIP_ACTIVE)
      else $error("sleep mapping wrong");
   deep_map_a: assert property (mcu_r == MCU_DEEP && !run |=> chip_mode_o == CHIP_DEEP
      && pwr_o.xtal_pll_off)
      else $error("deep sleep chip mode wrong");
   lsi_max_a: assert property (extended_beacon_skip_policy && run && associated_i |-> elapsed_r <= max_eff)
      else $error("long sleep exceeded maximum");
   shut_rtc_a: assert property (mcu_r == MCU_SHUTDOWN |=> !pwr_o.rtc_run && pwr_o.mem_lost)
      else $error("clock runs in shutdown");
   host_wake_a: assert property (host_cmd_i && run |=> !lp[BLK_NP])
      else $error("host command did not wake processor");
endmodule
`default_nettype wire

// *** tb/test_wsp_power_seq.sv ***
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ns
`default_nettype none
module test_wsp_power_seq;
   import wsp_pkg::*;
   localparam int TU = 8;
   typedef struct {string nm; int sel; logic [15:0] exp;} wsp_note_t;
   logic clk_i, rst_i, wfi_i, wfe_i, mcu_wake_i, integrated_i, internal_enable_i;
   logic hibernate_control_pin_i, stop_cmd_i, host_cmd_i, evt_i, evt_status_read_i;
   logic start_status_read_i, radio_busy_i, np_busy_i, predicted_activity_i;
   logic associated_i, client_mode_i, policy_we_i, want_on, svc;
   logic host_irq_o, init_done_o, radio_wake_o, power_save_en_o;
   logic mdns_stop_o, web_stop_o, slow_clk_stab_o;
   logic [15:0] stop_timeout_tu_i, tmo;
   logic [11:0] max_sleep_tu_i;
   logic [2:0]  dtim_period_i;
   wsp_mcu_t    mcu_mode_req_i, mcu_mode_o;
   wsp_pol_t    policy_sel_i;
   wsp_chip_t   chip_mode_o;
   wsp_pwr_t    pwr_o;
   int          gap, error_cnt, compares, cyc;
   wsp_note_t   notes[$];
   wsp_note_t   nt;
   event        chk_ev;

   wsp_power_seq #(.TU_CYCLES(TU), .BOOT_CYC(8), .STAB_CYC(4)) wsp_power_seq_inst (
      .clk_i, .rst_i, .mcu_mode_req_i, .wfi_i, .wfe_i, .mcu_wake_i, .integrated_i,
      .hibernate_control_pin_i, .internal_enable_i, .stop_cmd_i, .stop_timeout_tu_i,
      .host_cmd_i, .evt_i, .evt_status_read_i, .start_status_read_i, .radio_busy_i,
      .np_busy_i, .predicted_activity_i, .associated_i, .client_mode_i, .policy_sel_i,
      .policy_we_i, .max_sleep_tu_i, .dtim_period_i, .chip_mode_o, .mcu_mode_o, .pwr_o,
      .host_irq_o, .init_done_o, .radio_wake_o, .power_save_en_o, .mdns_stop_o,
      .web_stop_o, .slow_clk_stab_o);

   wsp_host_model wsp_host_model_inst (
      .clk_i, .rst_i, .want_on_i(want_on), .svc_i(svc), .tmo_i(tmo),
      .host_irq_i(host_irq_o), .pin_o(hibernate_control_pin_i), .stop_o(stop_cmd_i),
      .tmo_o(stop_timeout_tu_i), .start_rd_o(start_status_read_i),
      .evt_rd_o(evt_status_read_i));

   function automatic logic [15:0] obs(int sel);
      case (sel)
         0: obs = 16'(chip_mode_o);
         1: obs = 16'(mcu_mode_o);
         2: obs = 16'(pwr_o);
         3: obs = 16'(host_irq_o);
         4: obs = 16'(init_done_o);
         5: obs = 16'({mdns_stop_o, web_stop_o});
         6: obs = 16'(power_save_en_o);
         7: obs = 16'(slow_clk_stab_o);
         8: obs = 16'(pwr_o.rtc_run);
         9: obs = 16'(pwr_o.mem_lost);
         default: obs = 16'(gap);
      endcase
   endfunction

   task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic note(string nm, int sel, logic [15:0] exp);
      notes.push_back('{nm, sel, exp});
      -> chk_ev;
   endtask

   always @(chk_ev)
      while (notes.size() > 0)
      begin
         nt = notes.pop_front();
         check(nt.nm, obs(nt.sel), nt.exp);
      end

   task automatic cyc_n(int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
      @(negedge clk_i);
   endtask

   task automatic wait_for(int sel, logic [15:0] v, int lim);
      for (int i = 0; i < lim && obs(sel) !== v; i++)
         @(negedge clk_i);
   endtask

   task automatic set_pol(wsp_pol_t p);
      policy_sel_i = p;
      pulse(policy_we_i);
   endtask

   task automatic give_verdict();
      $display("Compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   initial
   begin
      rst_i = 1'b1;
      cyc = 0;
      mcu_mode_req_i = MCU_ACTIVE;
      policy_sel_i = POL_NORMAL;
      {wfi_i, wfe_i, mcu_wake_i, integrated_i, internal_enable_i, host_cmd_i} = 6'h00;
      {evt_i, np_busy_i, predicted_activity_i, associated_i, client_mode_i} = 5'h00;
      {policy_we_i, want_on, svc} = 3'h1;
      void'($urandom(52434));
      radio_busy_i = 1'($urandom);
      max_sleep_tu_i = 12'($urandom_range(1953, 100));
      dtim_period_i = 3'($urandom_range(4, 1));
      tmo = 16'($urandom_range(4, 1));
      cyc_n(5);
      rst_i = 1'b0;
      cyc_n(2);
      note("chip", 0, CHIP_ACTIVE);
      note("mcu", 1, MCU_ACTIVE);
      note("pwr", 2, 16'h0004);
      $display("Test reset done");
      want_on = 1'b1;
      wait_for(3, 1, 30);
      note("irq", 3, 1);
      wait_for(4, 1, 20);
      note("init", 4, 1);
      $display("Test boot done");
      radio_busy_i = 1'b0;
      svc = 1'b0;
      mcu_mode_req_i = MCU_DEEP;
      pulse(evt_i);
      cyc_n(12 * TU);
      note("chip", 0, CHIP_ACTIVE);
      note("irq", 3, 1);
      svc = 1'b1;
      wait_for(0, CHIP_DEEP, 12 * TU);
      note("chip", 0, CHIP_DEEP);
      note("irq", 3, 0);
      note("pwr", 2, 16'h003c);
      pulse(host_cmd_i);
      wait_for(0, CHIP_ACTIVE, 10);
      note("chip", 0, CHIP_ACTIVE);
      predicted_activity_i = 1'b1;
      cyc_n(12 * TU);
      note("chip", 0, CHIP_ACTIVE);
      set_pol(POL_LOW);
      wait_for(0, CHIP_DEEP, 3 * TU);
      note("chip", 0, CHIP_DEEP);
      set_pol(POL_ALWAYS);
      pulse(host_cmd_i);
      cyc_n(12 * TU);
      note("chip", 0, CHIP_ACTIVE);
      note("psave", 6, 0);
      $display("Test sleep policy done");
      predicted_activity_i = 1'b0;
      associated_i = 1'b1;
      set_pol(POL_NORMAL);
      for (int i = 0; i < 1000 && radio_wake_o !== 1'b1; i++)
         @(negedge clk_i);
      gap = 0;
      do
      begin
         @(negedge clk_i);
         gap++;
      end while (radio_wake_o !== 1'b1 && gap < 2000);
      note("beacon", 10, 16'(100 * TU));
      associated_i = 1'b0;
      client_mode_i = 1'b1;
      set_pol(POL_LONG);
      cyc_n(2 * TU);
      note("svc_stop", 5, 16'h0003);
      $display("Test beacon done");
      set_pol(POL_NORMAL);
      np_busy_i = 1'b1;
      cyc_n(2 * TU);
      note("chip", 0, CHIP_ACTIVE);
      want_on = 1'b0;
      cyc_n(int'(tmo) * TU + 20);
      note("chip", 0, CHIP_DEEP);
      $display("Test stop done");
      np_busy_i = 1'b0;
      mcu_mode_req_i = MCU_ACTIVE;
      cyc_n(3);
      for (int k = 0; k < 2; k++)
      begin
         if (k == 0)
            pulse(wfi_i);
         else
            pulse(wfe_i);
         cyc_n(3);
         note("mcu", 1, MCU_SLEEP);
         note("chip", 0, CHIP_ACTIVE);
         note("pwr", 2, 16'h0005);
         pulse(mcu_wake_i);
         cyc_n(3);
         note("mcu", 1, MCU_ACTIVE);
      end
      mcu_mode_req_i = MCU_SHUTDOWN;
      cyc_n(4);
      note("mcu", 1, MCU_SHUTDOWN);
      note("rtc", 8, 0);
      note("lost", 9, 1);
      mcu_mode_req_i = MCU_ACTIVE;
      cyc_n(3);
      note("stab", 7, 1);
      wait_for(1, MCU_ACTIVE, 20);
      note("mcu", 1, MCU_ACTIVE);
      mcu_mode_req_i = MCU_HIBERNATE;
      cyc_n(4);
      note("mcu", 1, MCU_HIBERNATE);
      note("rtc", 8, 1);
      $display("Test mcu modes done");
      cyc_n(2);
      give_verdict();
   end
endmodule
`default_nettype wire

// *** tb/wsp_host_model.sv ***
// Host model: enable pin, stop command and status reads
`timescale 1ns/1ns
`default_nettype none
module wsp_host_model
   import wsp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        want_on_i,
   input  wire logic        svc_i,
   input  wire logic [15:0] tmo_i,
   input  wire logic        host_irq_i,
   output var logic         pin_o,
   output var logic         stop_o,
   output var logic [15:0]  tmo_o,
   output var logic         start_rd_o,
   output var logic         evt_rd_o
);
   logic booted;
   logic stopping;
   initial
   begin
      {pin_o, stop_o, start_rd_o, evt_rd_o, booted, stopping} = 6'h00;
      tmo_o = 16'h0000;
      forever
      begin
         @(negedge clk_i);
         {stop_o, start_rd_o, evt_rd_o} = 3'h0;
         if (rst_i)
            {pin_o, booted, stopping} = 3'h0;
         else if (stopping)
         begin
            pin_o = 1'b0;
            stopping = 1'b0;
         end
         else if (want_on_i && !pin_o)
         begin
            pin_o = 1'b1;
            booted = 1'b0;
         end
         else if (!want_on_i && pin_o)
         begin
            stop_o = 1'b1;
            tmo_o = tmo_i;
            stopping = 1'b1;
         end
         else if (host_irq_i === 1'b1 && !booted)
         begin
            start_rd_o = 1'b1;
            booted = 1'b1;
         end
         else if (host_irq_i === 1'b1 && svc_i)
            evt_rd_o = 1'b1;
      end
   end
endmodule
`default_nettype wire
